// ==== cvr_regs.sv ====
// Overview of operation
// [R1] two ranges, each with sixteen levels chosen by a four-bit level code
// [R2] bit five of the reference control register picks the active range
// [R3] ranges differ in step size per code; one range has finer steps
// [R4] bit four of the control register picks the ladder supply source
// [R5] software waits for the reference to settle after changing its settings
// [R6] status bit nine mirrors the second comparator's current event flag
// [R7] control bits fifteen to eight read zero, ignore writes; low byte resets zero
// [R8] idle-stop clear keeps comparators running in idle; set halts them
// [R9] source zero feeds ladder from supply rails, one from external reference pins
`timescale 1ns/1ps
`include "cvr_map.svh"
module cvr_regs
   import cvr_pkg::*;
#(
   parameter int SETTLE_NS = `CVR_SETTLE_NS
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // register port
   input cvr_bus_t bus,
   output logic [`CVR_DATA_W-1:0] rd_data,
   // comparator cores, asynchronous
   input cvr_cmp_t cmp_in,
   // power management
   input wire logic device_idle,
   output logic cmp_run,
   // ladder
   output cvr_ctrl_t vref,
   output logic ladder_supply,
   output logic [`CVR_RATIO_W-1:0] ref_output_level,
   // interrupt
   output logic irq
);

   localparam int SETTLE_CYC = (SETTLE_NS + `CVR_CLK_NS - 1) / `CVR_CLK_NS;
   localparam logic [`CVR_CNT_W-1:0] SETTLE_LOAD = `CVR_CNT_W'(SETTLE_CYC);

   if (SETTLE_CYC < 1 || SETTLE_CYC >= (1 << `CVR_CNT_W)) begin : g_chk
      $error("cvr_regs: settling count does not fit the counter");
   end

   ////////////////////////////////////////////////////////////////////////////
   // state, inputs and ladder

   cvr_state_t st_q;
   cvr_state_t st_d;
   cvr_cmp_t cmp;
   logic [$bits(cvr_cmp_t)-1:0] cmp_raw;
   logic [`CVR_RATIO_W-1:0] lad_ratio;

   cvr_sync #(
      .W($bits(cvr_cmp_t))
   ) u_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .async_in(cmp_in),
      .sync_out(cmp_raw)
   );

   assign cmp = cvr_cmp_t'(cmp_raw);

   // ratio follows the registered settings, so it trails them by one cycle
   cvr_ladder u_ladder (
      .ctrl(st_q.ctrl),
      .ratio(lad_ratio)
   );

   function automatic logic hit(input cvr_bus_t b, input logic [7:0] off);
      hit = (b.addr == off);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next state

   logic wr_ctrl;
   logic setup_change;
   logic settle_done;
   logic [`CVR_IRQ_W-1:0] ev;
   logic [`CVR_IRQ_W-1:0] clr;
   cvr_ctrl_t new_ctrl;

   always_comb begin
      st_d = st_q;
      st_d.rd_data = '0;
      wr_ctrl = bus.wr && hit(bus, `CVR_OFF_CTRL);
      new_ctrl = cvr_ctrl_t'(bus.wdata[`CVR_CTRL_HI:`CVR_CTRL_LO]); // R7
      setup_change = wr_ctrl &&
         ((new_ctrl[`CVR_SETUP_HI:0] != st_q.ctrl[`CVR_SETUP_HI:0]) ||
          (new_ctrl.en && !st_q.ctrl.en));
      settle_done = st_q.settling && (st_q.settle_cnt == `CVR_CNT_W'(1)) && !setup_change;
      clr = '0;

      // register writes
      if (wr_ctrl) begin
         st_d.ctrl = new_ctrl; // R1 R2 R4
      end
      if (bus.wr && hit(bus, `CVR_OFF_MODE)) begin
         st_d.idle_stop = bus.wdata[`CVR_MODE_IDLE];
      end
      if (bus.wr && hit(bus, `CVR_OFF_IRQS)) begin
         clr = bus.wdata[`CVR_IRQ_W-1:0];
      end
      if (bus.wr && hit(bus, `CVR_OFF_IRQM)) begin
         st_d.irq_msk = bus.wdata[`CVR_IRQ_W-1:0];
      end

      // settling wait, restarted by every change of level, range or source
      if (setup_change) begin
         st_d.settle_cnt = SETTLE_LOAD;
         st_d.settling = 1'b1;
      end else if (st_q.settling) begin
         st_d.settle_cnt = st_q.settle_cnt - `CVR_CNT_W'(1);
         if (settle_done) begin
            st_d.settling = 1'b0;
         end
      end

      // events; a set in the clearing cycle wins so no event is lost
      ev = '0;
      ev[`CVR_IRQ_EVT1] = cmp.evt1 && !st_q.cmp_prev.evt1;
      ev[`CVR_IRQ_EVT2] = cmp.evt2 && !st_q.cmp_prev.evt2;
      ev[`CVR_IRQ_SETTLE] = settle_done;
      st_d.cmp_prev = cmp;
      st_d.irq_sts = (st_q.irq_sts & ~clr) | ev;
      st_d.irq = |(st_d.irq_sts & st_d.irq_msk);

      // idle handling
      st_d.run = !(st_q.idle_stop && device_idle); // R8
      st_d.ratio = lad_ratio;

      // reads, data valid in the following cycle only
      if (bus.rd) begin
         if (hit(bus, `CVR_OFF_CTRL)) begin
            st_d.rd_data[`CVR_CTRL_HI:`CVR_CTRL_LO] = st_q.ctrl; // R7
         end else if (hit(bus, `CVR_OFF_STAT)) begin
            st_d.rd_data[`CVR_STAT_EVT2] = cmp.evt2; // R6
            st_d.rd_data[`CVR_STAT_EVT1] = cmp.evt1;
            st_d.rd_data[`CVR_STAT_RES2] = cmp.res2;
            st_d.rd_data[`CVR_STAT_RES1] = cmp.res1;
         end else if (hit(bus, `CVR_OFF_MODE)) begin
            st_d.rd_data[`CVR_MODE_IDLE] = st_q.idle_stop;
            st_d.rd_data[`CVR_MODE_BUSY] = st_q.settling;
         end else if (hit(bus, `CVR_OFF_IRQS)) begin
            st_d.rd_data[`CVR_IRQ_W-1:0] = st_q.irq_sts;
         end else if (hit(bus, `CVR_OFF_IRQM)) begin
            st_d.rd_data[`CVR_IRQ_W-1:0] = st_q.irq_msk;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '0;
         st_q.ctrl <= cvr_ctrl_t'(`CVR_CTRL_RST); // R7
         st_q.run <= 1'b1;
         st_q.ratio <= `CVR_COARSE_BASE;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign rd_data = st_q.rd_data;
   assign vref = st_q.ctrl;
   assign ladder_supply = st_q.ctrl.src; // R9
   assign ref_output_level = st_q.ratio;
   assign cmp_run = st_q.run;
   assign irq = st_q.irq;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   property p_r1_level;
      @(posedge ref_clk) disable iff (!reset_n)
      (bus.wr && bus.addr == `CVR_OFF_CTRL) |=> ##1
         ref_output_level == ($past(vref.range) ? 7'($past(vref.level)) * `CVR_FINE_STEP
                              : `CVR_COARSE_BASE + 7'($past(vref.level)) * `CVR_COARSE_STEP);
   endproperty
   a_r1_level: assert property (p_r1_level) // R1
      else $error("ladder ratio does not follow the level code");

   property p_r2_range;
      @(posedge ref_clk) disable iff (!reset_n)
      (bus.wr && bus.addr == `CVR_OFF_CTRL) |=> vref.range == $past(bus.wdata[`CVR_BIT_RANGE]);
   endproperty
   a_r2_range: assert property (p_r2_range) // R2
      else $error("range select not taken from bit five");

   property p_r3_fine;
      @(posedge ref_clk) disable iff (!reset_n)
      vref.range |=> ref_output_level == 7'($past(vref.level)) * `CVR_FINE_STEP;
   endproperty
   a_r3_fine: assert property (p_r3_fine) // R3
      else $error("fine range step wrong");

   property p_r4_source;
      @(posedge ref_clk) disable iff (!reset_n)
      (bus.wr && bus.addr == `CVR_OFF_CTRL) |=> vref.src == $past(bus.wdata[`CVR_BIT_SRC]);
   endproperty
   a_r4_source: assert property (p_r4_source) // R4
      else $error("source select not taken from bit four");

   property p_r6_event;
      @(posedge ref_clk) disable iff (!reset_n)
      (bus.rd && bus.addr == `CVR_OFF_STAT) |=> rd_data[`CVR_STAT_EVT2] == $past(cmp.evt2);
   endproperty
   a_r6_event: assert property (p_r6_event) // R6
      else $error("status bit nine does not mirror second event");

   property p_r7_upper;
      @(posedge ref_clk) disable iff (!reset_n)
      (bus.rd && bus.addr == `CVR_OFF_CTRL) |=>
         rd_data[`CVR_DATA_W-1:`CVR_CTRL_HI+1] == '0 && rd_data[`CVR_CTRL_HI:0] == $past(vref);
   endproperty
   a_r7_upper: assert property (p_r7_upper) // R7
      else $error("control read back wrong");

   property p_r8_idle;
      @(posedge ref_clk) disable iff (!reset_n)
      1'b1 |=> cmp_run == !($past(st_q.idle_stop) && $past(device_idle));
   endproperty
   a_r8_idle: assert property (p_r8_idle) // R8
      else $error("comparator run does not follow idle stop");

   property p_r9_supply;
      @(posedge ref_clk) disable iff (!reset_n)
      (bus.wr && bus.addr == `CVR_OFF_CTRL) |=> ladder_supply == $past(bus.wdata[`CVR_BIT_SRC]);
   endproperty
   a_r9_supply: assert property (p_r9_supply) // R9
      else $error("ladder supply does not follow source select");

   property p_r1_code;
      @(posedge ref_clk) disable iff (!reset_n)
      (bus.wr && bus.addr == `CVR_OFF_CTRL) |=>
         vref.level == $past(bus.wdata[`CVR_LVL_HI:`CVR_LVL_LO]);
   endproperty
   a_r1_code: assert property (p_r1_code) // R1
      else $error("level code not taken from the low nibble");

   property p_r3_coarse;
      @(posedge ref_clk) disable iff (!reset_n)
      !vref.range |=>
         ref_output_level == `CVR_COARSE_BASE + 7'($past(vref.level)) * `CVR_COARSE_STEP;
   endproperty
   a_r3_coarse: assert property (p_r3_coarse) // R3
      else $error("coarse range step wrong");

   property p_r6_first;
      @(posedge ref_clk) disable iff (!reset_n)
      (bus.rd && bus.addr == `CVR_OFF_STAT) |=> rd_data[`CVR_STAT_EVT1] == $past(cmp.evt1);
   endproperty
   a_r6_first: assert property (p_r6_first) // R6
      else $error("status bit eight does not mirror first event");

   property p_r6_unused;
      @(posedge ref_clk) disable iff (!reset_n)
      (bus.rd && bus.addr == `CVR_OFF_STAT) |=>
         rd_data[`CVR_DATA_W-1:`CVR_STAT_EVT2+1] == '0 &&
         rd_data[`CVR_STAT_EVT1-1:`CVR_STAT_RES2+1] == '0;
   endproperty
   a_r6_unused: assert property (p_r6_unused) // R6
      else $error("unused status bits not zero");

   property p_r7_low;
      @(posedge ref_clk) disable iff (!reset_n)
      (bus.wr && bus.addr == `CVR_OFF_CTRL) |=>
         vref == cvr_ctrl_t'($past(bus.wdata[`CVR_CTRL_HI:`CVR_CTRL_LO]));
   endproperty
   a_r7_low: assert property (p_r7_low) // R7
      else $error("control low byte not taken from write data");

   property p_r7_hold;
      @(posedge ref_clk) disable iff (!reset_n)
      !(bus.wr && bus.addr == `CVR_OFF_CTRL) |=> $stable(vref);
   endproperty
   a_r7_hold: assert property (p_r7_hold) // R7
      else $error("control changed without a control write");

   property p_r7_quiet;
      @(posedge ref_clk) disable iff (!reset_n)
      !bus.rd |=> rd_data == '0;
   endproperty
   a_r7_quiet: assert property (p_r7_quiet) // R7
      else $error("read data not zero outside a read");

   property p_r8_halt;
      @(posedge ref_clk) disable iff (!reset_n)
      (st_q.idle_stop && device_idle) |=> !cmp_run;
   endproperty
   a_r8_halt: assert property (p_r8_halt) // R8
      else $error("comparators not halted in idle");

   property p_r8_keep;
      @(posedge ref_clk) disable iff (!reset_n)
      !st_q.idle_stop |=> cmp_run;
   endproperty
   a_r8_keep: assert property (p_r8_keep) // R8
      else $error("comparators halted with idle stop clear");

   property p_r8_readback;
      @(posedge ref_clk) disable iff (!reset_n)
      (bus.rd && bus.addr == `CVR_OFF_MODE) |=>
         rd_data[`CVR_MODE_IDLE] == $past(st_q.idle_stop);
   endproperty
   a_r8_readback: assert property (p_r8_readback) // R8
      else $error("idle stop bit read back wrong");

   property p_r9_hold;
      @(posedge ref_clk) disable iff (!reset_n)
      !(bus.wr && bus.addr == `CVR_OFF_CTRL) |=> $stable(ladder_supply);
   endproperty
   a_r9_hold: assert property (p_r9_hold) // R9
      else $error("ladder supply changed without a control write");

endmodule

// ==== cvr_map.svh ====
`ifndef CVR_MAP_SVH
`define CVR_MAP_SVH

// register offsets, byte addresses on the plain register port
`define CVR_ADDR_W 8
`define CVR_DATA_W 16
`define CVR_OFF_CTRL 8'h00
`define CVR_OFF_STAT 8'h04
`define CVR_OFF_MODE 8'h08
`define CVR_OFF_IRQS 8'h0C
`define CVR_OFF_IRQM 8'h10

// reference control register
`define CVR_CTRL_RST 8'h00
`define CVR_CTRL_HI 7
`define CVR_CTRL_LO 0
`define CVR_BIT_EN 7
`define CVR_BIT_OE 6
`define CVR_BIT_RANGE 5
`define CVR_BIT_SRC 4
`define CVR_LVL_HI 3
`define CVR_LVL_LO 0
`define CVR_SETUP_HI 5

// comparator summary register
`define CVR_STAT_EVT2 9
`define CVR_STAT_EVT1 8
`define CVR_STAT_RES2 1
`define CVR_STAT_RES1 0

// comparator mode register
`define CVR_MODE_IDLE 15
`define CVR_MODE_BUSY 0

// interrupt status and mask layout
`define CVR_IRQ_W 3
`define CVR_IRQ_EVT1 0
`define CVR_IRQ_EVT2 1
`define CVR_IRQ_SETTLE 2

// ladder ratio, numerator over a denominator of 96
`define CVR_RATIO_W 7
`define CVR_FINE_STEP 7'h04
`define CVR_COARSE_BASE 7'h18
`define CVR_COARSE_STEP 7'h03

// settling wait
`define CVR_SETTLE_NS 10000
`define CVR_CLK_NS 10
`define CVR_CNT_W 16

`endif

// ==== cvr_pkg.sv ====
package cvr_pkg;

   // layout matches the low byte of the reference control register
   typedef struct packed {
      logic en;
      logic oe;
      logic range;
      logic src;
      logic [3:0] level;
   } cvr_ctrl_t;

   typedef struct packed {
      logic evt2;
      logic evt1;
      logic res2;
      logic res1;
   } cvr_cmp_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } cvr_bus_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic val;
   } cvr_sync_t;

   typedef struct packed {
      cvr_ctrl_t ctrl;
      logic idle_stop;
      logic [2:0] irq_sts;
      logic [2:0] irq_msk;
      cvr_cmp_t cmp_prev;
      logic [15:0] settle_cnt;
      logic settling;
      logic [15:0] rd_data;
      logic irq;
      logic run;
      logic [6:0] ratio;
   } cvr_state_t;

endpackage

// ==== cvr_sync.sv ====
`timescale 1ns/1ps
module cvr_sync
   import cvr_pkg::*;
#(
   parameter int W = 4
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // lanes
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   if (W < 1) begin : g_chk
      $error("cvr_sync: W must be at least 1");
   end

   // a lane only moves once the second and third stage agree
   for (genvar i = 0; i < W; i++) begin : g_lane
      cvr_sync_t st_q;
      cvr_sync_t st_d;
      always_comb begin
         st_d = st_q;
         st_d.s1 = async_in[i];
         st_d.s2 = st_q.s1;
         st_d.s3 = st_q.s2;
         if (st_q.s2 == st_q.s3) begin
            st_d.val = st_q.s3;
         end
      end
      always_ff @(posedge ref_clk or negedge reset_n) begin
         if (!reset_n) begin
            st_q <= '0;
         end else begin
            st_q <= st_d;
         end
      end
      assign sync_out[i] = st_q.val;
   end

endmodule

// ==== cvr_ladder.sv ====
`timescale 1ns/1ps
`include "cvr_map.svh"
module cvr_ladder
   import cvr_pkg::*;
(
   // settings
   input cvr_ctrl_t ctrl,
   // tap ratio over 96
   output logic [`CVR_RATIO_W-1:0] ratio
);

   // fine range: level/24, coarse range: 1/4 + level/32
   always_comb begin
      if (ctrl.range) begin
         ratio = 7'(ctrl.level) * `CVR_FINE_STEP; // R3
      end else begin
         ratio = `CVR_COARSE_BASE + 7'(ctrl.level) * `CVR_COARSE_STEP; // R3
      end
   end

endmodule

// ==== cmp_vref_ctrl_status_regs_tb.sv ====
`timescale 1ns/1ps
`include "cvr_map.svh"
module cmp_vref_ctrl_status_regs_tb
   import cvr_pkg::*;
;
   logic ref_clk;
   logic reset_n;
   cvr_bus_t bus;
   logic [15:0] rd_data;
   cvr_cmp_t cmp_in;
   logic device_idle;
   logic cmp_run;
   cvr_ctrl_t vref;
   logic ladder_supply;
   logic [6:0] ref_output_level;
   logic irq;
   int n_fail;
   int comparisons;

   // short settle count keeps the run brief: 50 ns is five cycles
   cvr_regs #(.SETTLE_NS(50)) DUT (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .bus(bus),
      .rd_data(rd_data),
      .cmp_in(cmp_in),
      .device_idle(device_idle),
      .cmp_run(cmp_run),
      .vref(vref),
      .ladder_supply(ladder_supply),
      .ref_output_level(ref_output_level),
      .irq(irq)
   );

   always #5 ref_clk = ~ref_clk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d, failures %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(logic [7:0] a, logic [15:0] d);
      @(posedge ref_clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge ref_clk);
      bus.wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(logic [7:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge ref_clk);
      bus.rd <= 1'b0;
      #1;
      d = rd_data;
   endtask

   task automatic wait_clk(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      logic [15:0] d;
      rd(`CVR_OFF_CTRL, d);
      chk("ctrl reset", 16'h0000, d);
      chk("vref reset", 16'h0000, {8'h00, vref});
      chk("level reset", 16'h0018, {9'h000, ref_output_level});
      chk("run reset", 16'h0001, {15'h0000, cmp_run});
      chk("irq reset", 16'h0000, {15'h0000, irq});
   endtask

   // every range and source, both ends of the level code
   task automatic t_ctrl();
      logic [15:0] tbl [6] = '{16'hFFA5, 16'h0050, 16'h002F, 16'h000F, 16'hFF30, 16'h00DA};
      logic [15:0] d;
      logic [6:0] lvl;
      foreach (tbl[i]) begin
         wr(`CVR_OFF_CTRL, tbl[i]);
         wait_clk(2);
         rd(`CVR_OFF_CTRL, d);
         chk("ctrl read", {8'h00, tbl[i][7:0]}, d);
         chk("vref", {8'h00, tbl[i][7:0]}, {8'h00, vref});
         chk("supply", {15'h0000, tbl[i][4]}, {15'h0000, ladder_supply});
         // fine range steps four per code, coarse range three above a base
         lvl = tbl[i][5] ? 7'(tbl[i][3:0]) * 7'h04 : 7'h18 + 7'(tbl[i][3:0]) * 7'h03;
         chk("level", {9'h000, lvl}, {9'h000, ref_output_level});
      end
      rd(8'h20, d);
      chk("unmapped", 16'h0000, d);
   endtask

   task automatic t_status();
      logic [15:0] d;
      wr(`CVR_OFF_IRQM, 16'h0000);
      wr(`CVR_OFF_IRQS, 16'h0007);
      cmp_in <= '{evt2: 1'b0, evt1: 1'b1, res2: 1'b0, res1: 1'b0};
      wait_clk(8);
      chk("irq masked", 16'h0000, {15'h0000, irq});
      rd(`CVR_OFF_IRQS, d);
      chk("irq status", 16'h0001, d);
      wr(`CVR_OFF_IRQM, 16'h0001);
      wait_clk(2);
      chk("irq raised", 16'h0001, {15'h0000, irq});
      wr(`CVR_OFF_IRQS, 16'h0001);
      wait_clk(2);
      chk("irq cleared", 16'h0000, {15'h0000, irq});
      @(posedge ref_clk);
      cmp_in <= '{evt2: 1'b1, evt1: 1'b1, res2: 1'b1, res1: 1'b1};
      wait_clk(8);
      rd(`CVR_OFF_STAT, d);
      chk("status all", 16'h0303, d);
      @(posedge ref_clk);
      cmp_in <= '{evt2: 1'b1, evt1: 1'b0, res2: 1'b0, res1: 1'b1};
      wait_clk(8);
      rd(`CVR_OFF_STAT, d);
      chk("status evt2", 16'h0201, d);
   endtask

   task automatic t_idle();
      @(posedge ref_clk);
      device_idle <= 1'b1;
      wait_clk(3);
      chk("run idle clear", 16'h0001, {15'h0000, cmp_run});
      wr(`CVR_OFF_MODE, 16'h8000);
      wait_clk(2);
      chk("run idle stop", 16'h0000, {15'h0000, cmp_run});
      @(posedge ref_clk);
      device_idle <= 1'b0;
      wait_clk(2);
      chk("run awake", 16'h0001, {15'h0000, cmp_run});
   endtask

   // software polls the busy bit before trusting the comparators again
   task automatic t_settle();
      logic [15:0] d;
      wr(`CVR_OFF_IRQS, 16'h0007);
      wr(`CVR_OFF_CTRL, 16'h0083);
      rd(`CVR_OFF_MODE, d);
      chk("busy while settling", 16'h8001, d);
      rd(`CVR_OFF_IRQS, d);
      chk("settle not done", 16'h0000, d);
      wait_clk(2);
      rd(`CVR_OFF_MODE, d);
      chk("settled", 16'h8000, d);
      rd(`CVR_OFF_IRQS, d);
      chk("settle event", 16'h0004, d);
      // rewriting the same setting must not start a new wait
      wr(`CVR_OFF_CTRL, 16'h0083);
      rd(`CVR_OFF_MODE, d);
      chk("same setting no wait", 16'h8000, d);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      reset_n = 1'b0;
      bus = '0;
      cmp_in = '0;
      device_idle = 1'b0;
      n_fail = 0;
      comparisons = 0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      wait_clk(1);
      t_reset();
      t_ctrl();
      t_status();
      t_idle();
      t_settle();
      close_out();
   end

   // the sequence needs under 120 cycles; far beyond that means a hang
   initial begin
      #200000;
      n_fail++;
      close_out();
   end
endmodule
